/* File: rtl/lsbfc_pkg.sv */
// constants and types for the led sink blink and fade control block
`default_nettype none

package lsbfc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] FADE_LAW_ADDR  = 8'h0F;
  localparam logic [7:0] ENABLE_ADDR    = 8'h10;
  localparam logic [7:0] TIME_UP_ADDR   = 8'h11;
  localparam logic [7:0] TIME_LO_ADDR   = 8'h12;

  localparam logic [7:0] FADE_LAW_RST   = 8'h00;
  localparam logic [7:0] ENABLE_RST     = 8'h00;
  localparam logic [7:0] TIME_UP_RST    = 8'h00;
  localparam logic [7:0] TIME_LO_RST    = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int NUM_SINKS      = 7;
  localparam int LAW_LSB        = 0;
  localparam int LIT_TIME_LSB   = 6;
  localparam int FIELD_W        = 2;
  localparam logic [1:0] DARK_DISABLED = 2'h0;
  localparam logic [7:0] ENABLE_MASK   = 8'h7F;
  localparam logic [7:0] LAW_MASK      = 8'h03;

  // fade law codes
  localparam logic [1:0] LAW_LINEAR  = 2'h0;
  localparam logic [1:0] LAW_SQUARE  = 2'h1;
  localparam logic [1:0] LAW_CUBIC10 = 2'h2;
  localparam logic [1:0] LAW_CUBIC11 = 2'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int BASE_TICK_MS   = 200;
  localparam int TICK_CYCLES    = CLK_HZ / 1000 * BASE_TICK_MS;
  localparam int TICK_CNT_W     = 23;
  localparam int LIT_MS_0       = 200;
  localparam int LIT_MS_1       = 600;
  localparam int LIT_MS_2       = 800;
  localparam int LIT_MS_3       = 1200;
  localparam int DARK_MS_1      = 600;
  localparam int DARK_MS_2      = 1200;
  localparam int DARK_MS_3      = 1800;
  localparam int PHASE_CNT_W    = 4;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic {PH_LIT, PH_DARK} lsbfc_phase_t;
  typedef enum logic [1:0] {STEP_LINEAR, STEP_CUBIC10, STEP_CUBIC11} lsbfc_step_t;

endpackage : lsbfc_pkg

`default_nettype wire

/* File: rtl/lsbfc_ctrl.sv */
// led sink blink timer, enables and fade law control
//
// Functional notes
// - fade law 00 selects the linear dac mapping with equal time per dac code.
// - fade law 01 selects the square dac mapping with equal time per dac code.
// - fade law 10 selects the square dac mapping with the first cubic time profile.
// - fade law 11 selects the square dac mapping with the second cubic time profile.
// - the enable register holds sink 1 to 7 in bits 0 to 6, bit 7 reserved, and a 1 turns a sink on.
// - a 0 in an enable bit turns the sink off regardless of its timing fields.
// - the shared lit time applies only to an enabled sink whose dark time is not disabled, then it goes dark.
// - the lit time field selects 0.2, 0.6, 0.8 or 1.2 s for codes 00 to 11.
// - a sink with dark time 00 stays lit for as long as it is enabled.
// - a sink with a nonzero dark time lights for the lit time, then goes dark for that time.
// - dark time codes 00 to 11 mean disabled, 0.6, 1.2 and 1.8 s.
// - the upper timing register holds sink 7, 6, 5 dark times in bits 5:4, 3:2, 1:0.
// - the lower timing register holds sink 4, 3, 2, 1 dark times in bits 7:6, 5:4, 3:2, 1:0.
`timescale 1ns/1ps
`default_nettype none

module lsbfc_ctrl #(
  parameter int TICK_CYCLES = lsbfc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // byte register port from the serial interface engine
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  // sink drive
  output logic      [6:0]                sink_lit,
  // fade law to the current dac path
  output logic                           dac_square_law,
  output lsbfc_pkg::lsbfc_step_t         fade_step_profile,
  // shared blink time base
  output logic                           blink_tick
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire logic rst_n = rst_sync_reg;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic [lsbfc_pkg::PHASE_CNT_W-1:0] lit_ticks(input logic [1:0] code);
    int ms;
    case (code)
      2'h0:    ms = lsbfc_pkg::LIT_MS_0;
      2'h1:    ms = lsbfc_pkg::LIT_MS_1;
      2'h2:    ms = lsbfc_pkg::LIT_MS_2;
      default: ms = lsbfc_pkg::LIT_MS_3;
    endcase
    lit_ticks = lsbfc_pkg::PHASE_CNT_W'(ms / lsbfc_pkg::BASE_TICK_MS);
  endfunction : lit_ticks

  function automatic logic [lsbfc_pkg::PHASE_CNT_W-1:0] dark_ticks(input logic [1:0] code);
    int ms;
    case (code)
      2'h1:    ms = lsbfc_pkg::DARK_MS_1;
      2'h2:    ms = lsbfc_pkg::DARK_MS_2;
      2'h3:    ms = lsbfc_pkg::DARK_MS_3;
      default: ms = 0;
    endcase
    dark_ticks = lsbfc_pkg::PHASE_CNT_W'(ms / lsbfc_pkg::BASE_TICK_MS);
  endfunction : dark_ticks

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [1:0] fade_law_sel_reg;
  logic [1:0] fade_law_sel_next;
  logic [6:0] enable_reg;
  logic [6:0] enable_next;
  logic [7:0] time_up_reg;
  logic [7:0] time_up_next;
  logic [7:0] time_lo_reg;
  logic [7:0] time_lo_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb
  begin
    fade_law_sel_next = fade_law_sel_reg;
    enable_next       = enable_reg;
    time_up_next      = time_up_reg;
    time_lo_next      = time_lo_reg;
    rdata_next        = rdata_reg;
    if (reg_wr)
    begin
      case (reg_addr)
        lsbfc_pkg::FADE_LAW_ADDR: fade_law_sel_next = reg_wdata[1:0];
        lsbfc_pkg::ENABLE_ADDR:   enable_next = reg_wdata[6:0];
        lsbfc_pkg::TIME_UP_ADDR:  time_up_next = reg_wdata;
        lsbfc_pkg::TIME_LO_ADDR:  time_lo_next = reg_wdata;
        default:                  ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        lsbfc_pkg::FADE_LAW_ADDR: rdata_next = {6'h00, fade_law_sel_reg};
        lsbfc_pkg::ENABLE_ADDR:   rdata_next = {1'b0, enable_reg};
        lsbfc_pkg::TIME_UP_ADDR:  rdata_next = time_up_reg;
        lsbfc_pkg::TIME_LO_ADDR:  rdata_next = time_lo_reg;
        default:                  rdata_next = lsbfc_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fade_law_sel_reg <= lsbfc_pkg::FADE_LAW_RST[1:0];
      enable_reg       <= lsbfc_pkg::ENABLE_RST[6:0];
      time_up_reg      <= lsbfc_pkg::TIME_UP_RST;
      time_lo_reg      <= lsbfc_pkg::TIME_LO_RST;
      rdata_reg        <= 8'h00;
    end
    else
    begin
      fade_law_sel_reg <= fade_law_sel_next;
      enable_reg       <= enable_next;
      time_up_reg      <= time_up_next;
      time_lo_reg      <= time_lo_next;
      rdata_reg        <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------
  // fade law decode
  // ------------------------------------------------------------
  logic                   square_reg;
  logic                   square_next;
  lsbfc_pkg::lsbfc_step_t step_reg;
  lsbfc_pkg::lsbfc_step_t step_next;

  always_comb
  begin
    case (fade_law_sel_reg)
      lsbfc_pkg::LAW_LINEAR:
      begin
        square_next = 1'b0;
        step_next   = lsbfc_pkg::STEP_LINEAR;
      end
      lsbfc_pkg::LAW_SQUARE:
      begin
        square_next = 1'b1;
        step_next   = lsbfc_pkg::STEP_LINEAR;
      end
      lsbfc_pkg::LAW_CUBIC10:
      begin
        square_next = 1'b1;
        step_next   = lsbfc_pkg::STEP_CUBIC10;
      end
      default:
      begin
        square_next = 1'b1;
        step_next   = lsbfc_pkg::STEP_CUBIC11;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      square_reg <= 1'b0;
      step_reg   <= lsbfc_pkg::STEP_LINEAR;
    end
    else
    begin
      square_reg <= square_next;
      step_reg   <= step_next;
    end
  end

  assign dac_square_law    = square_reg;
  assign fade_step_profile = step_reg;

  // ------------------------------------------------------------
  // shared time base
  // ------------------------------------------------------------
  localparam logic [lsbfc_pkg::TICK_CNT_W-1:0] TICK_LAST = lsbfc_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  logic [lsbfc_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic [lsbfc_pkg::TICK_CNT_W-1:0] tick_cnt_next;
  logic                             tick_reg;
  logic                             tick_next;

  // one time base for all sinks
  always_comb
  begin
    tick_next = (tick_cnt_reg == TICK_LAST);
    if (tick_next)
      tick_cnt_next = '0;
    else
      tick_cnt_next = tick_cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  assign blink_tick = tick_reg;

  // ------------------------------------------------------------
  // per sink blink sequencer
  // ------------------------------------------------------------
  // dark time fields, sink 1 lowest
  wire logic [13:0] dark_fields = {time_up_reg[5:0], time_lo_reg};
  wire logic [1:0]  lit_code    = time_up_reg[lsbfc_pkg::LIT_TIME_LSB +: lsbfc_pkg::FIELD_W];

  genvar g;
  generate
    for (g = 0; g < lsbfc_pkg::NUM_SINKS; g++)
    begin : g_sink
      lsbfc_pkg::lsbfc_phase_t              phase_reg;
      lsbfc_pkg::lsbfc_phase_t              phase_next;
      logic [lsbfc_pkg::PHASE_CNT_W-1:0]    cnt_reg;
      logic [lsbfc_pkg::PHASE_CNT_W-1:0]    cnt_next;
      logic                                 lit_reg;
      logic                                 lit_next;
      logic [1:0]                           dark_code;
      logic [lsbfc_pkg::PHASE_CNT_W-1:0]    limit;

      always_comb
      begin
        dark_code  = dark_fields[g*lsbfc_pkg::FIELD_W +: lsbfc_pkg::FIELD_W];
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        limit = (phase_reg == lsbfc_pkg::PH_LIT) ? lit_ticks(lit_code) : dark_ticks(dark_code);
        if (!enable_reg[g])
        begin
          // disable wins; restart lit on next enable
          phase_next = lsbfc_pkg::PH_LIT;
          cnt_next   = '0;
        end
        else if (dark_code == lsbfc_pkg::DARK_DISABLED)
        begin
          phase_next = lsbfc_pkg::PH_LIT;
          cnt_next   = '0;
        end
        else if (tick_reg)
        begin
          if (cnt_reg + 1'b1 >= limit)
          begin
            cnt_next = '0;
            case (phase_reg)
              lsbfc_pkg::PH_LIT:  phase_next = lsbfc_pkg::PH_DARK;
              lsbfc_pkg::PH_DARK: phase_next = lsbfc_pkg::PH_LIT;
              default:            phase_next = lsbfc_pkg::PH_LIT;
            endcase
          end
          else
            cnt_next = cnt_reg + 1'b1;
        end
        lit_next = enable_reg[g] && (phase_next == lsbfc_pkg::PH_LIT);
      end

      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          phase_reg <= lsbfc_pkg::PH_LIT;
          cnt_reg   <= '0;
          lit_reg   <= 1'b0;
        end
        else
        begin
          phase_reg <= phase_next;
          cnt_reg   <= cnt_next;
          lit_reg   <= lit_next;
        end
      end

      assign sink_lit[g] = lit_reg;
    end
  endgenerate

endmodule : lsbfc_ctrl

`default_nettype wire

/* File: verif/lsbfc_ctrl_chk.sv */
// port assertions for the sink blink and fade control block
`timescale 1ns/1ps
`default_nettype none

module lsbfc_ctrl_chk #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  // register port
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  // outputs
  input wire logic [6:0]             sink_lit,
  input wire logic                   dac_square_law,
  input wire lsbfc_pkg::lsbfc_step_t fade_step_profile,
  input wire logic                   blink_tick
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // --------------------------------------------------------
  // helper state
  // --------------------------------------------------------
  logic [7:0] en_reg;
  logic [7:0] en_d_reg;
  int         gap_reg;
  logic       seen_reg;

  // enable shadow lags one cycle so a sink falling a cycle late is legal
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      en_reg   <= 8'h00;
      en_d_reg <= 8'h00;
      gap_reg  <= 0;
      seen_reg <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == lsbfc_pkg::ENABLE_ADDR)
        en_reg <= reg_wdata;
      en_d_reg <= en_reg;
      gap_reg  <= blink_tick ? 0 : gap_reg + 1;
      seen_reg <= seen_reg | blink_tick;
    end
  end

  function automatic lsbfc_pkg::lsbfc_step_t prof(input logic [7:0] d);
    return (d[1:0] == 2'h2) ? lsbfc_pkg::STEP_CUBIC10 :
           (d[1:0] == 2'h3) ? lsbfc_pkg::STEP_CUBIC11 : lsbfc_pkg::STEP_LINEAR;
  endfunction : prof

  // --------------------------------------------------------
  // sequences and assertions
  // --------------------------------------------------------
  sequence law_wr;
    reg_wr && reg_addr == lsbfc_pkg::FADE_LAW_ADDR;
  endsequence
  sequence en_wr;
    reg_wr && reg_addr == lsbfc_pkg::ENABLE_ADDR;
  endsequence

  law_map_a: assert property (law_wr |-> ##2 dac_square_law == ($past(reg_wdata[1:0], 2) != 2'h0))
    else $error("dac map does not follow fade law");
  profile_map_a: assert property (law_wr |-> ##2 fade_step_profile == prof($past(reg_wdata, 2)))
    else $error("step profile does not follow fade law");
  unmapped_rd_a: assert property (reg_rd && (reg_addr < 8'h0F || reg_addr > 8'h12) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  enable_read_a: assert property (reg_rd && reg_addr == lsbfc_pkg::ENABLE_ADDR |=> reg_rdata == ($past(en_reg) & 8'h7F))
    else $error("enable readback wrong");
  enable_off_a: assert property (en_wr |-> ##2 (sink_lit & ~$past(reg_wdata[6:0], 2)) == 7'h00)
    else $error("disabled sink still lit");
  lit_enabled_a: assert property ((sink_lit & ~en_d_reg[6:0]) == 7'h00)
    else $error("sink lit without enable");
  tick_gap_a: assert property (seen_reg |-> blink_tick == (gap_reg == TICK_CYCLES - 1))
    else $error("blink tick spacing wrong");
  sink_change_a: assert property (!$stable(sink_lit) |-> $past(blink_tick) || $past(blink_tick, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("sink changed off the time base");
endmodule : lsbfc_ctrl_chk

bind lsbfc_ctrl lsbfc_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES)) i_lsbfc_ctrl_chk (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sink_lit(sink_lit), .dac_square_law(dac_square_law),
  .fade_step_profile(fade_step_profile), .blink_tick(blink_tick)
);

`default_nettype wire

/* File: verif/lsbfc_host.sv */
// host model that issues byte register accesses
`timescale 1ns/1ps
`default_nettype none

module lsbfc_host (
  // clock
  input wire logic  clk_sys,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'hFF;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // data is inverted once released so a stale byte cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd
endmodule : lsbfc_host

`default_nettype wire

/* File: verif/test_led_sink_blink_fade_ctrl.sv */
// testbench for the sink blink and fade control block
`timescale 1ns/1ps
`default_nettype none

module test_led_sink_blink_fade_ctrl;
  localparam int TICK = 4;
  logic                   clk_sys;
  logic                   nrst;
  logic [7:0]             reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_rdata;
  logic [6:0]             sink_lit;
  logic                   dac_square_law;
  lsbfc_pkg::lsbfc_step_t fade_step_profile;
  logic                   blink_tick;
  logic [7:0]             d;
  int                     n;
  int                     fail_count;
  int                     compares;
  int                     lit_t[4]  = '{1, 3, 4, 6};
  int                     dark_t[4] = '{0, 3, 6, 9};
  lsbfc_pkg::lsbfc_step_t prof_exp[4] = '{lsbfc_pkg::STEP_LINEAR, lsbfc_pkg::STEP_LINEAR,
                                          lsbfc_pkg::STEP_CUBIC10, lsbfc_pkg::STEP_CUBIC11};

  lsbfc_ctrl #(.TICK_CYCLES(TICK)) i_lsbfc_ctrl (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sink_lit(sink_lit), .dac_square_law(dac_square_law),
    .fade_step_profile(fade_step_profile), .blink_tick(blink_tick)
  );
  lsbfc_host i_lsbfc_host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // cycles a sink holds one level, capped so a stuck sink cannot hang
  task automatic span(input int s, input logic lvl, output int c);
    c = 0;
    while (sink_lit[s] === lvl && c < 100)
    begin
      @(negedge clk_sys);
      c++;
    end
  endtask : span

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end

  initial
  begin
    nrst = 1'b0;
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int a = 8'h0F; a <= 8'h13; a++)
    begin
      i_lsbfc_host.rd(8'(a), d);
      chk(d, 8'h00);
    end
    for (int i = 0; i < 4; i++)
    begin
      i_lsbfc_host.wr(lsbfc_pkg::FADE_LAW_ADDR, 8'hFC | 8'(i));
      i_lsbfc_host.rd(lsbfc_pkg::FADE_LAW_ADDR, d);
      chk(d, 8'(i));
      chk({7'h00, dac_square_law}, {7'h00, i != 0});
      chk({6'h00, fade_step_profile}, {6'h00, prof_exp[i]});
    end
    i_lsbfc_host.wr(lsbfc_pkg::ENABLE_ADDR, 8'hFF);
    i_lsbfc_host.rd(lsbfc_pkg::ENABLE_ADDR, d);
    chk(d, 8'h7F);
    repeat (5 * TICK) @(negedge clk_sys);
    chk({1'b0, sink_lit}, 8'h7F);
    // every sink blinks in turn, covering all lit codes and dark codes 01 to 11
    for (int s = 0; s < 7; s++)
    begin
      i_lsbfc_host.wr(lsbfc_pkg::ENABLE_ADDR, 8'h00);
      @(negedge clk_sys);
      chk({1'b0, sink_lit}, 8'h00);
      d = 8'(s % 3 + 1) << (2 * (s % 4));
      i_lsbfc_host.wr(lsbfc_pkg::TIME_UP_ADDR, (8'(s % 4) << 6) | (s >= 4 ? d : 8'h00));
      i_lsbfc_host.wr(lsbfc_pkg::TIME_LO_ADDR, s < 4 ? d : 8'h00);
      i_lsbfc_host.wr(lsbfc_pkg::ENABLE_ADDR, 8'h01 << s);
      @(negedge clk_sys);
      span(s, 1'b1, n);
      span(s, 1'b0, n);
      chk(8'(n), 8'(dark_t[s % 3 + 1] * TICK));
      span(s, 1'b1, n);
      chk(8'(n), 8'(lit_t[s % 4] * TICK));
      span(s, 1'b0, n);
      chk(8'(n), 8'(dark_t[s % 3 + 1] * TICK));
    end
    results();
  end
endmodule : test_led_sink_blink_fade_ctrl

`default_nettype wire
